// ### pkg/ecpt_pkg.sv
// constants and carrier types of the eight channel pwm timer
`default_nettype none
package ecpt_pkg;
  localparam int NCH = 8;
  localparam int NPAIR = 4;
  localparam int DW = 8;
  localparam int AW = 8;
  // register offsets; arrays take eight consecutive bytes
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_POLARITY = 8'h01;
  localparam logic [7:0] OFF_CENTER = 8'h02;
  localparam logic [7:0] OFF_CONCAT = 8'h03;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h10;
  localparam logic [7:0] OFF_DUTY = 8'h18;
  // reset values
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [3:0] RST_CONCAT = 4'h0;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_CNT = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ecpt_req_s;
endpackage : ecpt_pkg
`default_nettype wire

// ### hdl/ecpt_top.sv
// eight channel pwm timer with pair concatenation and register port
//
// Behaviour
// - eight channels, 8 bits each, own counter, free running waveform each
// - software sets period and duty per channel
// - duty covers 0 percent through 100 percent of period inclusive; center aligned with a period of all ones misses 100 percent by one clock
// - polarity bit picks whether duty portion drives high or low
// - each channel left aligned or center aligned (up/down triangle)
// - pairs 7/6, 5/4, 3/2, 1/0 each joinable into 16-bit channel
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ecpt_top
  import ecpt_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire ecpt_req_s req,
  output logic [DW-1:0] rdata,
  // waveform pins
  output logic [NCH-1:0] pwm_out
);

  logic [NCH-1:0] en_reg, en_next;
  logic [NCH-1:0] pol_reg, pol_next;
  logic [NCH-1:0] ctr_reg, ctr_next;
  logic [NPAIR-1:0] cat_reg, cat_next;
  logic [DW-1:0] per_reg [NCH];
  logic [DW-1:0] per_next [NCH];
  logic [DW-1:0] duty_reg [NCH];
  logic [DW-1:0] duty_next [NCH];
  logic [DW-1:0] cnt_reg [NCH];
  logic [DW-1:0] cnt_next [NCH];
  logic [NCH-1:0] dir_reg, dir_next;
  logic [NCH-1:0] out_reg, out_next;
  logic [DW-1:0] rdata_reg, rdata_next;
  logic [16:0] s;
  logic act;
  logic [2:0] idx;

  assign idx = req.addr[2:0];
  assign rdata = rdata_reg;
  assign pwm_out = out_reg;

  // one counter step; returns {down, count}; width covers joined pairs
  function automatic logic [16:0] step(input logic [15:0] c,
                                       input logic [15:0] p,
                                       input logic ctr,
                                       input logic dn);
    logic [16:0] r;
    r = {dn, c};
    if (p == 16'h0000)
    begin
      r = 17'h0_0000;
    end
    else if (!ctr)
    begin
      // a period lowered under the count wraps at once
      if (c >= p - 16'h0001)
        r = 17'h0_0000;
      else
        r = {1'b0, c + 16'h0001};
    end
    else if (!dn)
    begin
      if (c < p)
        r = {1'b0, c + 16'h0001};
      else
        r = {1'b1, c - 16'h0001};
    end
    else
    begin
      if (c != 16'h0000)
        r = {1'b1, c - 16'h0001};
      else
        r = {1'b0, c + 16'h0001};
    end
    return r;
  endfunction : step

  // register file
  always_comb
  begin
    en_next = en_reg;
    pol_next = pol_reg;
    ctr_next = ctr_reg;
    cat_next = cat_reg;
    per_next = per_reg;
    duty_next = duty_reg;
    rdata_next = RST_CFG;
    if (req.wr)
    begin
      if (req.addr == OFF_ENABLE)
        en_next = req.wdata;
      else if (req.addr == OFF_POLARITY)
        pol_next = req.wdata;
      else if (req.addr == OFF_CENTER)
        ctr_next = req.wdata;
      else if (req.addr == OFF_CONCAT)
        cat_next = req.wdata[NPAIR-1:0];
      else if (req.addr[7:3] == OFF_PERIOD[7:3])
        per_next[idx] = req.wdata;
      else if (req.addr[7:3] == OFF_DUTY[7:3])
        duty_next[idx] = req.wdata;
    end
    if (req.rd)
    begin
      if (req.addr == OFF_ENABLE)
        rdata_next = en_reg;
      else if (req.addr == OFF_POLARITY)
        rdata_next = pol_reg;
      else if (req.addr == OFF_CENTER)
        rdata_next = ctr_reg;
      else if (req.addr == OFF_CONCAT)
        rdata_next = {4'h0, cat_reg};
      else if (req.addr[7:3] == OFF_COUNT[7:3])
        rdata_next = cnt_reg[idx];
      else if (req.addr[7:3] == OFF_PERIOD[7:3])
        rdata_next = per_reg[idx];
      else if (req.addr[7:3] == OFF_DUTY[7:3])
        rdata_next = duty_reg[idx];
    end
  end

  // counters and outputs, one pair at a time
  always_comb
  begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    out_next = out_reg;
    s = 17'h0_0000;
    act = 1'b0;
    for (int p = 0; p < NPAIR; p++)
    begin
      if (cat_reg[p])
      begin
        // upper channel owns enable, polarity and alignment
        s = step({cnt_reg[2*p+1], cnt_reg[2*p]},
                 {per_reg[2*p+1], per_reg[2*p]},
                 ctr_reg[2*p+1], dir_reg[2*p+1]);
        act = {cnt_reg[2*p+1], cnt_reg[2*p]} <
              {duty_reg[2*p+1], duty_reg[2*p]};
        if (!en_reg[2*p+1])
          s = 17'h0_0000;
        {dir_next[2*p+1], cnt_next[2*p+1], cnt_next[2*p]} = s;
        dir_next[2*p] = 1'b0;
        out_next[2*p+1] = en_reg[2*p+1] ? (act ~^ pol_reg[2*p+1])
                                        : !pol_reg[2*p+1];
        out_next[2*p] = !pol_reg[2*p];
      end
      else
      begin
        for (int h = 0; h < 2; h++)
        begin
          s = step({8'h00, cnt_reg[2*p+h]}, {8'h00, per_reg[2*p+h]},
                   ctr_reg[2*p+h], dir_reg[2*p+h]);
          act = cnt_reg[2*p+h] < duty_reg[2*p+h];
          if (!en_reg[2*p+h])
            s = 17'h0_0000;
          dir_next[2*p+h] = s[16];
          cnt_next[2*p+h] = s[7:0];
          out_next[2*p+h] = en_reg[2*p+h] ? (act ~^ pol_reg[2*p+h])
                                          : !pol_reg[2*p+h];
        end
      end
    end
    // a write to a counter restarts it, whatever was written
    if (req.wr && req.addr[7:3] == OFF_COUNT[7:3])
    begin
      cnt_next[idx] = RST_CNT;
      dir_next[idx] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      en_reg <= RST_CFG;
      pol_reg <= RST_CFG;
      ctr_reg <= RST_CFG;
      cat_reg <= RST_CONCAT;
      dir_reg <= RST_CFG;
      out_reg <= ~RST_CFG;
      rdata_reg <= RST_CFG;
      for (int i = 0; i < NCH; i++)
      begin
        per_reg[i] <= RST_PERIOD;
        duty_reg[i] <= RST_DUTY;
        cnt_reg[i] <= RST_CNT;
      end
    end
    else
    begin
      en_reg <= en_next;
      pol_reg <= pol_next;
      ctr_reg <= ctr_next;
      cat_reg <= cat_next;
      dir_reg <= dir_next;
      out_reg <= out_next;
      rdata_reg <= rdata_next;
      per_reg <= per_next;
      duty_reg <= duty_next;
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_left_wrap: assert property (
    en_reg[0] && !cat_reg[0] && !ctr_reg[0] && !req.wr &&
    per_reg[0] != 8'h00 && cnt_reg[0] == per_reg[0] - 8'h01
    |=> cnt_reg[0] == 8'h00)
    else $error("channel 0 did not wrap at period end");

  a_period_read: assert property (
    req.rd && req.addr == OFF_PERIOD && !req.wr
    |=> rdata == $past(per_reg[0]) ##1 rdata == 8'h00 || $past(req.rd))
    else $error("period read returned wrong data");

  a_duty_active: assert property (
    en_reg[0] && !cat_reg[0] && cnt_reg[0] < duty_reg[0]
    |=> pwm_out[0] == $past(pol_reg[0]))
    else $error("channel 0 not active inside duty");

  a_duty_zero: assert property (
    en_reg[0] && !cat_reg[0] && duty_reg[0] == 8'h00
    |=> pwm_out[0] == !$past(pol_reg[0]))
    else $error("zero duty produced active output");

  a_idle_level: assert property (
    !en_reg[2] && !cat_reg[1] |=> pwm_out[2] == !$past(pol_reg[2]))
    else $error("disabled channel not at inactive level");

  a_center_turn: assert property (
    en_reg[0] && !cat_reg[0] && ctr_reg[0] && !dir_reg[0] && !req.wr &&
    per_reg[0] != 8'h00 && cnt_reg[0] == per_reg[0]
    |=> dir_reg[0] && cnt_reg[0] == $past(cnt_reg[0]) - 8'h01)
    else $error("center aligned counter did not turn");

  a_pair_carry: assert property (
    cat_reg[0] && en_reg[1] && !ctr_reg[1] && !req.wr &&
    cnt_reg[0] == 8'hFF &&
    {cnt_reg[1], cnt_reg[0]} + 16'h0001 < {per_reg[1], per_reg[0]}
    |=> cnt_reg[0] == 8'h00 && cnt_reg[1] == $past(cnt_reg[1]) + 8'h01)
    else $error("joined pair did not carry into upper byte");

  a_pair_output: assert property (
    cat_reg[0] && en_reg[1] &&
    {cnt_reg[1], cnt_reg[0]} < {duty_reg[1], duty_reg[0]}
    |=> pwm_out[1] == $past(pol_reg[1]) && pwm_out[0] == !$past(pol_reg[0]))
    else $error("joined pair output wrong");

  // stale read data would look like a second answer
  a_read_idle: assert property (
    !req.rd |=> rdata == 8'h00)
    else $error("read data did not return to zero");

  a_count_clear: assert property (
    req.wr && req.addr == OFF_COUNT
    |=> cnt_reg[0] == 8'h00 && !dir_reg[0])
    else $error("counter write did not restart channel 0");

  // a stopped channel must restart from zero, not mid period
  a_disabled_hold: assert property (
    !en_reg[0] && !cat_reg[0] |=> cnt_reg[0] == 8'h00)
    else $error("disabled channel 0 counter moved");

  // bottom of the triangle is visited once per waveform period
  a_center_bottom: assert property (
    en_reg[0] && !cat_reg[0] && ctr_reg[0] && dir_reg[0] && !req.wr &&
    per_reg[0] != 8'h00 && cnt_reg[0] == 8'h00
    |=> !dir_reg[0] && cnt_reg[0] == 8'h01)
    else $error("center aligned counter did not turn at zero");

  // the lower pin of a joined pair parks at its own inactive level
  for (genvar g = 0; g < NPAIR; g++)
  begin : g_pair_chk
    a_pair_low_pin: assert property (
      cat_reg[g] |=> pwm_out[2*g] == !$past(pol_reg[2*g]))
      else $error("lower pin of joined pair not at idle level");
    a_pair_idle: assert property (
      cat_reg[g] && !en_reg[2*g+1]
      |=> pwm_out[2*g+1] == !$past(pol_reg[2*g+1]))
      else $error("disabled joined pair not at idle level");
  end

  c_left_wrap: cover property (
    en_reg[0] && !ctr_reg[0] && cnt_reg[0] != 8'h00 ##1 cnt_reg[0] == 8'h00);
  c_center_turn: cover property (
    en_reg[0] && ctr_reg[0] && !dir_reg[0] ##1 dir_reg[0]);
  c_pair_carry: cover property (
    cat_reg[0] && en_reg[1] && cnt_reg[0] == 8'hFF ##1 cnt_reg[1] != 8'h00);
  c_full_duty: cover property (
    en_reg[0] && duty_reg[0] > per_reg[0] && per_reg[0] != 8'h00);
  c_all_joined: cover property (
    cat_reg == 4'hf && en_reg == 8'haa);

endmodule : ecpt_top
`default_nettype wire

// ### tb/tb_ecpt_top.sv
// self-checking testbench of the eight channel pwm timer
`timescale 1ns/1ps
`default_nettype none
module tb_ecpt_top
  import ecpt_pkg::*;
;
  logic clk_sys;
  logic rst_n;
  ecpt_req_s req;
  logic [DW-1:0] rdata;
  logic [NCH-1:0] pwm_out;
  int bad_count;
  int tests_run;
  int cnt [NCH];
  logic [7:0] duty_tab [NCH];

  ecpt_top dut
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req(req),
    .rdata(rdata),
    .pwm_out(pwm_out)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    chk("rdata", {8'h00, exp}, {8'h00, rdata});
    @(posedge clk_sys);
    #1;
    chk("rdata idle", 16'h0000, {8'h00, rdata});
  endtask : rd

  // counting whole waveform periods keeps the result phase independent
  task automatic measure(input int cycles);
    cnt = '{default: 0};
    repeat (cycles)
    begin
      @(negedge clk_sys);
      for (int i = 0; i < NCH; i++)
        if (pwm_out[i] === 1'b1)
          cnt[i]++;
    end
  endtask : measure

  // active cycles in 16 clocks with period 8
  function automatic logic [15:0] exp_hi(input logic [7:0] d,
                                         input logic ctr);
    if (d > 8'h08)
      return 16'h0010;
    if (d == 8'h00)
      return 16'h0000;
    return ctr ? {7'h00, d, 1'b0} - 16'h0001 : {7'h00, d, 1'b0};
  endfunction : exp_hi

  task automatic run_all(input logic ctr, input logic pol);
    logic [15:0] e;
    wr(OFF_ENABLE, 8'hff);
    repeat (20) @(posedge clk_sys);
    measure(16);
    for (int n = 0; n < NCH; n++)
    begin
      e = exp_hi(duty_tab[n], ctr);
      if (!pol)
        e = 16'h0010 - e;
      chk("pin", e, 16'(cnt[n]));
    end
    wr(OFF_ENABLE, 8'h00);
  endtask : run_all

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    bad_count = 0;
    tests_run = 0;
    duty_tab = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("pwm_out", 16'h00ff, {8'h00, pwm_out});
    rd(OFF_PERIOD, RST_PERIOD);
    wr(8'h04, 8'h5a);
    rd(8'h04, 8'h00);
    $display("test reset done");
    for (int n = 0; n < NCH; n++)
    begin
      wr(OFF_PERIOD + 8'(n), 8'h08);
      wr(OFF_DUTY + 8'(n), duty_tab[n]);
    end
    rd(OFF_DUTY + 8'h07, 8'h09);
    // cleared counter has stepped once when the read is taken
    wr(OFF_ENABLE, 8'h01);
    wr(OFF_COUNT, 8'h33);
    rd(OFF_COUNT, 8'h01);
    rd(OFF_COUNT + 8'h01, 8'h00);
    rd(OFF_ENABLE, 8'h01);
    wr(OFF_POLARITY, 8'hff);
    rd(OFF_POLARITY, 8'hff);
    run_all(1'b0, 1'b1);
    wr(OFF_POLARITY, 8'h00);
    run_all(1'b0, 1'b0);
    wr(OFF_POLARITY, 8'hff);
    wr(OFF_CENTER, 8'hff);
    rd(OFF_CENTER, 8'hff);
    run_all(1'b1, 1'b1);
    $display("test channels done");
    // pair 1/0 joined: period 16'h0100, duty 16'h0080
    wr(OFF_CENTER, 8'h00);
    wr(OFF_PERIOD, 8'h00);
    wr(OFF_PERIOD + 8'h01, 8'h01);
    wr(OFF_DUTY, 8'h80);
    wr(OFF_DUTY + 8'h01, 8'h00);
    wr(OFF_CONCAT, 8'h01);
    rd(OFF_CONCAT, 8'h01);
    wr(OFF_POLARITY, 8'h02);
    wr(OFF_ENABLE, 8'h02);
    repeat (4) @(posedge clk_sys);
    measure(512);
    chk("pin1", 16'h0100, 16'(cnt[1]));
    chk("pin0", 16'h0200, 16'(cnt[0]));
    chk("pin2", 16'h0200, 16'(cnt[2]));
    $display("test join done");
    // every pair joined: period 16'h0100, duty 16'h0080
    for (int p = 0; p < NPAIR; p++)
    begin
      wr(OFF_PERIOD + 8'(2*p), 8'h00);
      wr(OFF_PERIOD + 8'(2*p + 1), 8'h01);
      wr(OFF_DUTY + 8'(2*p), 8'h80);
      wr(OFF_DUTY + 8'(2*p + 1), 8'h00);
    end
    wr(OFF_POLARITY, 8'haa);
    wr(OFF_CONCAT, 8'h0f);
    wr(OFF_ENABLE, 8'haa);
    repeat (4) @(posedge clk_sys);
    measure(512);
    for (int p = 0; p < NPAIR; p++)
    begin
      chk("pair pin", 16'h0100, 16'(cnt[2*p+1]));
      chk("pair low pin", 16'h0200, 16'(cnt[2*p]));
    end
    $display("test all pairs done");
    summarize();
  end
endmodule : tb_ecpt_top
`default_nettype wire
